// ---- rtc_cfg.svh ----
// Offsets, field positions, reset values and timing for the clock core.
// Assumes inclusion by bare name from the core file and the test bench.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// System clock rate and the timekeeping step
`define RTC_CLK_HZ      40000000
`define RTC_TICK_MS     10
// Serial access lengths
`define RTC_SEQ_LEN     64
`define RTC_PTR_W       6
// Register indices in serial order
`define RTC_REG_HUND    3'h0
`define RTC_REG_SEC     3'h1
`define RTC_REG_MIN     3'h2
`define RTC_REG_HOUR    3'h3
`define RTC_REG_DAY     3'h4
`define RTC_REG_DATE    3'h5
`define RTC_REG_MON     3'h6
`define RTC_REG_YEAR    3'h7
// Field positions
`define RTC_HR_MODE_BIT 7
`define RTC_HR_PM_BIT   5
`define RTC_DAY_RMSK    4
`define RTC_DAY_OSC     5
// Implemented bits per register (others read zero)
`define RTC_MASK_HUND   8'hFF
`define RTC_MASK_SEC    8'h7F
`define RTC_MASK_MIN    8'h7F
`define RTC_MASK_HOUR   8'hBF
`define RTC_MASK_DAY    8'h37
`define RTC_MASK_DATE   8'h3F
`define RTC_MASK_MON    8'h1F
`define RTC_MASK_YEAR   8'hFF
// Reset values
`define RTC_RST_ZERO    8'h00
`define RTC_RST_ONE     8'h01
`define RTC_RST_DAY     8'h31

`endif

// ---- rtc_pkg.sv ----
// Types shared by the clock core.
// Assumes rtc_cfg.svh is on the include path.
`default_nettype none
package rtc_pkg;
  // Bus pins sampled together
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq;
    logic rst_n;
  } rtc_pins_t;
  // Serial access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MATCH = 2'b01,
    ST_XFER  = 2'b10
  } rtc_state_t;
endpackage
`default_nettype wire

// ---- rtc_ctrl.sv ----
// Timekeeping core reached through pattern-unlocked serial access.
// Assumes asynchronous SRAM-style pins, sampled on CLK_SYS.
//
// What this block does
// - Hours bit 7 selects 12 or 24 hour
// - 12-hour: hours bit 5 is PM flag
// - 24-hour: hours bit 5 is tens-of-twenty
// - Mask bit set ignores external reset pin
// - Mask clear: reset pin aborts, data kept
// - Stop bit set halts the oscillator
// - Stop bit clear advances time normally
// - Mask and stop bits set after reset
// - Unused bits of registers 1-6 read zero
// - Read then 64 matching writes unlock
// - Mismatch stalls; any read outside a transfer restarts pointer
// - Then 64 cycles move clock data, memory inhibited
// - Eight BCD bytes, LSB first, whole bytes
`include "rtc_cfg.svh"
`default_nettype none

module rtc_ctrl
  import rtc_pkg::*;
#(
  // Unlock pattern, value arbitrary
  parameter logic [63:0] UNLOCK_PAT = 64'h5A3C_96F0_0FC3_A569,
  // System cycles per 10 ms time step
  parameter int          TICK_CYC   =
    `RTC_CLK_HZ / 1000 * `RTC_TICK_MS
)(
  input  wire logic CLK_SYS,
  input  wire logic RESET_N,
  input  wire logic CE_N,
  input  wire logic OE_N,
  input  wire logic WE_N,
  input  wire logic SDL_I,
  input  wire logic EXT_RST_N,
  output logic      SDL_O,
  output logic      SDL_OE,
  output logic      MEM_INHIBIT,
  output logic      OSC_RUN
);

  localparam logic [7:0] MASK [8] = '{
    `RTC_MASK_HUND, `RTC_MASK_SEC, `RTC_MASK_MIN, `RTC_MASK_HOUR,
    `RTC_MASK_DAY, `RTC_MASK_DATE, `RTC_MASK_MON, `RTC_MASK_YEAR};

  logic [1:0]     rst_pipe;     // Reset release pair
  logic           rst_n_q;      // Synchronised reset
  rtc_pins_t      pin_raw;      // Pins gathered
  rtc_pins_t      pin_m;        // First sync stage
  rtc_pins_t      pin_s;        // Second sync stage
  logic           act;          // Access active now
  logic           act_reg;      // Access active before
  logic           wr_seen_reg;  // Write strobe seen
  logic           dbit_reg;     // Last written data bit
  logic           cyc_end;      // Access just ended
  logic           wr_end;       // Write ended
  logic           rd_end;       // Read ended
  logic           abort;        // Pin reset honoured
  rtc_state_t     state_reg;    // Sequencer state
  rtc_state_t     state_next;   // Its next value
  logic [`RTC_PTR_W-1:0] ptr_reg; // Bit pointer
  logic [63:0]    snap_reg;     // Read image
  logic [6:0]     wsh_reg;      // Byte being written
  logic [7:0]     time_reg [8]; // Time registers
  logic [7:0]     tk [8];       // Stepped time
  logic [31:0]    tick_cnt_reg; // Step divider
  logic           tick;         // Step pulse
  logic           osc_stop;     // Oscillator stop bit

  // Release system reset through two flops
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_q = rst_pipe[1];

  // Two-flop synchronisers on all pins
  assign pin_raw = '{CE_N, OE_N, WE_N, SDL_I, EXT_RST_N};
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_m <= 5'h1F;
      pin_s <= 5'h1F;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
    end
  end

  // Access framing from chip enable and strobes
  assign act     = !pin_s.ce_n && (!pin_s.we_n || !pin_s.oe_n);
  assign cyc_end = act_reg && !act;
  assign wr_end  = cyc_end && wr_seen_reg;
  assign rd_end  = cyc_end && !wr_seen_reg;
  assign osc_stop = time_reg[`RTC_REG_DAY][`RTC_DAY_OSC];
  assign abort = !time_reg[`RTC_REG_DAY][`RTC_DAY_RMSK]
                 && !pin_s.rst_n;

  // Track access, write strobe and data bit
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      act_reg     <= 1'b0;
      wr_seen_reg <= 1'b0;
      dbit_reg    <= 1'b0;
    end else begin
      act_reg <= act;
      if (!act_reg && act) begin
        wr_seen_reg <= !pin_s.we_n;
      end else if (act && !pin_s.we_n) begin
        wr_seen_reg <= 1'b1;
      end
      // Latest level before the strobe rises
      if (act && !pin_s.we_n) begin
        dbit_reg <= pin_s.dq;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rd_end) begin
          state_next = ST_MATCH;
        end
      end
      ST_MATCH: begin
        if (rd_end) begin
          state_next = ST_MATCH;
        end else if (wr_end && dbit_reg != UNLOCK_PAT[ptr_reg]) begin
          state_next = ST_IDLE;
        end else if (wr_end && &ptr_reg) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (cyc_end && &ptr_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  // State and bit pointer
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_reg <= ST_IDLE;
      ptr_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (abort || state_next != state_reg || rd_end
          && state_reg != ST_XFER) begin
        ptr_reg <= '0;
      end else if (state_reg == ST_MATCH && wr_end
                   || state_reg == ST_XFER && cyc_end) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
    end
  end

  // Snapshot on unlock, byte shifter, data out
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      snap_reg    <= '0;
      wsh_reg     <= '0;
      SDL_O       <= 1'b0;
      SDL_OE      <= 1'b0;
      MEM_INHIBIT <= 1'b0;
      OSC_RUN     <= 1'b0;
    end else begin
      if (state_reg == ST_MATCH && state_next == ST_XFER) begin
        snap_reg <= {time_reg[7], time_reg[6], time_reg[5],
                     time_reg[4], time_reg[3], time_reg[2],
                     time_reg[1], time_reg[0]};
      end
      if (state_reg == ST_XFER && wr_end) begin
        wsh_reg <= {dbit_reg, wsh_reg[6:1]};
      end
      SDL_OE <= state_next == ST_XFER && act && pin_s.we_n
                && !pin_s.oe_n;
      SDL_O  <= snap_reg[ptr_reg];
      MEM_INHIBIT <= state_next == ST_XFER;
      OSC_RUN     <= !osc_stop;
    end
  end

  // Step divider for 10 ms time steps
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_reg <= '0;
    end else if (tick || osc_stop) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = tick_cnt_reg == 32'(TICK_CYC - 1);

  // BCD increment with wrap, carry in bit 8
  function automatic logic [8:0] bump(logic [7:0] v, logic [7:0] lim,
                                      logic [7:0] base);
    if (v >= lim) begin
      bump = {1'b1, base};
    end else if (v[3:0] >= 4'h9) begin
      bump = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bump = {1'b0, v + 8'h01};
    end
  endfunction

  // Days in month with four-year leap rule
  function automatic logic [7:0] dim(logic [7:0] m, logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02:   dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  endfunction

  // Carry chain for one time step
  always_comb begin
    logic [8:0] r;
    logic       cy;
    logic [4:0] h;
    r  = '0;
    h  = time_reg[3][4:0];
    tk = time_reg;
    cy = tick && !osc_stop;
    if (cy) begin
      r = bump(time_reg[0], 8'h99, 8'h00);
      tk[0] = r[7:0];
      cy = r[8];
    end
    if (cy) begin
      r = bump(time_reg[1], 8'h59, 8'h00);
      tk[1] = r[7:0];
      cy = r[8];
    end
    if (cy) begin
      r = bump(time_reg[2], 8'h59, 8'h00);
      tk[2] = r[7:0];
      cy = r[8];
    end
    if (cy) begin
      if (time_reg[3][`RTC_HR_MODE_BIT]) begin
        cy = h == 5'h11 && time_reg[3][`RTC_HR_PM_BIT];
        if (h == 5'h11) begin
          tk[3][`RTC_HR_PM_BIT] = !time_reg[3][`RTC_HR_PM_BIT];
        end
        tk[3][4:0] = h == 5'h12 ? 5'h01 : 5'(bump({3'h0, h},
                     8'h12, 8'h01));
      end else begin
        r = bump({2'b00, time_reg[3][5:0]}, 8'h23, 8'h00);
        tk[3][5:0] = r[5:0];
        cy = r[8];
      end
    end
    if (cy) begin
      tk[4][2:0] = time_reg[4][2:0] >= 3'h7 ? 3'h1
                   : time_reg[4][2:0] + 3'h1;
      r = bump(time_reg[5], dim(time_reg[6], time_reg[7]), 8'h01);
      tk[5] = r[7:0];
      cy = r[8];
    end
    if (cy) begin
      r = bump(time_reg[6], 8'h12, 8'h01);
      tk[6] = r[7:0];
      cy = r[8];
    end
    if (cy) begin
      r = bump(time_reg[7], 8'h99, 8'h00);
      tk[7] = r[7:0];
    end
  end

  // Time registers, stepped or written bytewise
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_reg
      always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
          time_reg[gi] <= gi == 4 ? `RTC_RST_DAY
                        : (gi == 5 || gi == 6) ? `RTC_RST_ONE
                        : `RTC_RST_ZERO;
        end else if (state_reg == ST_XFER && wr_end && !abort
                     && ptr_reg == 6'(gi * 8 + 7)) begin
          time_reg[gi] <= {dbit_reg, wsh_reg} & MASK[gi];
        end else begin
          time_reg[gi] <= tk[gi] & MASK[gi];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n_q);

  chk_osc_hold: assert property (
    osc_stop && !(state_reg == ST_XFER && wr_end)
    |=> time_reg[0] == $past(time_reg[0]))
    else $error("Time moved while stopped");
  chk_osc_step: assert property (
    tick && !osc_stop && state_reg != ST_XFER
    |=> time_reg[0] != $past(time_reg[0]))
    else $error("Time step lost");
  chk_pm_flip: assert property (
    tick && !osc_stop && state_reg != ST_XFER && time_reg[0] == 8'h99
    && time_reg[1] == 8'h59 && time_reg[2] == 8'h59
    && time_reg[3][7] && time_reg[3][4:0] == 5'h11
    |=> time_reg[3][5] != $past(time_reg[3][5])
        && time_reg[3][4:0] == 5'h12)
    else $error("PM flag not flipped at twelve");
  chk_twenty_wrap: assert property (
    tick && !osc_stop && state_reg != ST_XFER && time_reg[0] == 8'h99
    && time_reg[1] == 8'h59 && time_reg[2] == 8'h59
    && time_reg[3] == 8'h23
    |=> time_reg[3] == 8'h00)
    else $error("24-hour wrap wrong");
  chk_mask_hold: assert property (
    time_reg[4][4] && state_reg == ST_XFER && !cyc_end
    |=> state_reg == ST_XFER)
    else $error("Masked reset pin acted");
  chk_pin_abort: assert property (
    abort |=> state_reg == ST_IDLE && !MEM_INHIBIT)
    else $error("Reset pin did not abort");
  chk_init_bits: assert property (disable iff (1'b0)
    !rst_n_q |=> !rst_n_q || time_reg[4][5:4] == 2'b11)
    else $error("Control bits not set at reset");
  chk_zero_bits: assert property (
    (time_reg[1][7] | time_reg[2][7] | time_reg[3][6]
     | time_reg[4][7] | time_reg[4][6] | time_reg[4][3]
     | time_reg[5][7] | time_reg[5][6] | |time_reg[6][7:5]) == 1'b0)
    else $error("Unused bit not zero");
  chk_match_step: assert property (
    state_reg == ST_MATCH && wr_end && !abort
    && dbit_reg == UNLOCK_PAT[ptr_reg] && !(&ptr_reg)
    |=> state_reg == ST_MATCH && ptr_reg == $past(ptr_reg) + 6'h1)
    else $error("Pointer did not advance");
  chk_mismatch: assert property (
    state_reg == ST_MATCH && wr_end
    && dbit_reg != UNLOCK_PAT[ptr_reg]
    |=> state_reg == ST_IDLE ##1 state_reg != ST_XFER)
    else $error("Mismatch did not stall");
  chk_read_reset: assert property (
    rd_end && state_reg != ST_XFER && !abort
    |=> state_reg == ST_MATCH && ptr_reg == 6'h0)
    else $error("Read did not restart compare");
  chk_xfer_len: assert property (
    state_reg == ST_XFER && cyc_end && &ptr_reg
    |=> state_reg == ST_IDLE && !MEM_INHIBIT)
    else $error("Transfer not ended after 64");
  chk_inhibit: assert property (
    state_reg == ST_XFER |-> MEM_INHIBIT)
    else $error("Memory not inhibited");

endmodule
`default_nettype wire

// ---- rtc_host_model.sv ----
// Host on the SRAM-style pins of the clock core.
// Assumes CLK_SYS free running; pins change on its falling edge.
`default_nettype none

module rtc_host_model #(
  parameter logic [63:0] PAT = 64'h0
)(
  input  wire logic CLK_SYS,
  input  wire logic DQ,
  input  wire logic SDL_OE,
  output var  logic CE_N,
  output var  logic OE_N,
  output var  logic WE_N,
  output var  logic HOST_DQ,
  output var  logic EXT_RST_N
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins, reset pin pulled high
  initial begin
    CE_N      = 1'b1;
    OE_N      = 1'b1;
    WE_N      = 1'b1;
    HOST_DQ   = 1'b0;
    EXT_RST_N = 1'b1;
  end

  // One access; strobes held long enough for the synchronisers
  task automatic acc(input logic we, input logic b,
                     output logic seen, output logic v);
    seen = 1'b0;
    v    = 1'b0;
    @(negedge CLK_SYS);
    CE_N    <= 1'b0;
    WE_N    <= !we;
    OE_N    <= we;
    // Unused line on reads keeps toggling
    HOST_DQ <= we ? b : !HOST_DQ;
    repeat (5) begin
      @(negedge CLK_SYS);
      if (SDL_OE === 1'b1) begin
        seen = 1'b1;
        v    = DQ;
      end
    end
    CE_N <= 1'b1;
    WE_N <= 1'b1;
    OE_N <= 1'b1;
    repeat (6) @(negedge CLK_SYS);
  endtask

  task automatic unlock(input int bad);
    logic s;
    logic v;
    acc(1'b0, 1'b0, s, v);
    for (int i = 0; i < 64; i++) begin
      acc(1'b1, PAT[i] ^ (i == bad), s, v);
    end
  endtask

  // Low pulse on the device reset pin
  task automatic rst_pulse();
    @(negedge CLK_SYS);
    EXT_RST_N <= 1'b0;
    repeat (8) @(negedge CLK_SYS);
    EXT_RST_N <= 1'b1;
    repeat (6) @(negedge CLK_SYS);
  endtask
endmodule

`default_nettype wire

// ---- rtc_ctrl_test.sv ----
// Self-checking bench for the clock core.
// Assumes rtc_cfg.svh on the include path, host model beside it.
`include "rtc_cfg.svh"
`default_nettype none

module rtc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary unlock pattern, short time step
  localparam logic [63:0] PAT  = 64'h0F1E_2D3C_4B5A_6978;
  localparam logic [63:0] MSK  = {`RTC_MASK_YEAR, `RTC_MASK_MON,
    `RTC_MASK_DATE, `RTC_MASK_DAY, `RTC_MASK_HOUR, `RTC_MASK_MIN,
    `RTC_MASK_SEC, `RTC_MASK_HUND};
  localparam logic [63:0] W1   = 64'h99F2_F1F1_F2D9_D999;
  // 24-hour 23:59:59.80 and the day after its roll-over
  localparam logic [63:0] W2   = 64'h2406_1502_2359_5980;
  localparam logic [63:0] W2R  = 64'h2406_1603_0000_0000;
  // 12-hour 11:59:59.50 AM and its turn to 12 PM
  localparam logic [63:0] W3   = 64'h2406_1502_9159_5950;
  localparam logic [63:0] W3R  = 64'h2406_1502_B200_0000;

  logic        clk_sys;
  logic        reset_n;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic        host_dq;
  logic        ext_rst_n;
  logic        sdl_o;
  logic        sdl_oe;
  logic        mem_inhibit;
  logic        osc_run;
  wire logic   dq;
  int          fails;
  int          checked;
  logic [63:0] d;

  // Shared data line: device wins while it drives
  assign dq = sdl_oe ? sdl_o : host_dq;

  // 40 MHz clock
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = !clk_sys;

  rtc_ctrl #(.UNLOCK_PAT(PAT), .TICK_CYC(20)) DUT (
    .CLK_SYS     (clk_sys),
    .RESET_N     (reset_n),
    .CE_N        (ce_n),
    .OE_N        (oe_n),
    .WE_N        (we_n),
    .SDL_I       (dq),
    .EXT_RST_N   (ext_rst_n),
    .SDL_O       (sdl_o),
    .SDL_OE      (sdl_oe),
    .MEM_INHIBIT (mem_inhibit),
    .OSC_RUN     (osc_run)
  );

  rtc_host_model #(.PAT(PAT)) host (
    .CLK_SYS   (clk_sys),
    .DQ        (dq),
    .SDL_OE    (sdl_oe),
    .CE_N      (ce_n),
    .OE_N      (oe_n),
    .WE_N      (we_n),
    .HOST_DQ   (host_dq),
    .EXT_RST_N (ext_rst_n)
  );

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read n transfer bits, device must drive each one
  task automatic xrd(input int n, output logic [63:0] r);
    logic s;
    logic v;
    r = 64'h0;
    for (int i = 0; i < n; i++) begin
      host.acc(1'b0, 1'b0, s, v);
      chk(s, 1'b1);
      r[i] = v;
    end
  endtask

  // Whole bytes, bit 0 of register 0 first
  task automatic xwr(input logic [63:0] w);
    logic s;
    logic v;
    for (int i = 0; i < 64; i++) begin
      host.acc(1'b1, w[i], s, v);
    end
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    fails   = 0;
    checked = 0;
    // Clean falling reset edge once every process waits on it
    reset_n = 1'b1;
    #1;
    reset_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // Fresh state: stopped, mask set
    chk(osc_run, 1'b0);
    chk(mem_inhibit, 1'b0);
    host.unlock(-1);
    chk(mem_inhibit, 1'b1);
    xrd(64, d);
    chk(d, 64'h0001_0131_0000_0000);
    chk(mem_inhibit, 1'b0);
    // Ones into zero bits, 12-hour PM, clock stays stopped
    host.unlock(-1);
    xwr(W1);
    chk(osc_run, 1'b0);
    host.unlock(-1);
    host.rst_pulse();
    chk(mem_inhibit, 1'b1);
    xrd(64, d);
    chk(d, W1 & MSK);
    chk(d[31:24], 8'hB2);
    // Start oscillator just before midnight, 24-hour, mask clear
    host.unlock(-1);
    xwr(W2);
    chk(osc_run, 1'b1);
    host.unlock(-1);
    xrd(64, d);
    chk(d[63:8], W2R[63:8]);
    chk(d[7:0] == 8'h00, 1'b0);
    // Reset pin aborts a transfer, data kept
    host.unlock(-1);
    xrd(10, d);
    host.rst_pulse();
    chk(mem_inhibit, 1'b0);
    // Mismatch stalls the pattern
    host.unlock(5);
    chk(mem_inhibit, 1'b0);
    host.unlock(-1);
    chk(mem_inhibit, 1'b1);
    xrd(64, d);
    chk(d[63:16], W2R[63:16]);
    chk(d[31], 1'b0);
    // Late morning in 12-hour mode turns to noon before the read
    host.unlock(-1);
    xwr(W3);
    host.unlock(-1);
    xrd(64, d);
    chk(d[63:8], W3R[63:8]);
    conclude();
  end
endmodule

`default_nettype wire
